// ---- hdl/api_frame_command_handler.sv ----
// Purpose: Parses host API frames, runs local parameter commands, emits answers
// Assumes: Byte streams synchronous to clock; radio path sits outside
// Notes: Answer frames pass through a small FIFO toward the UART transmitter
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clock,              // System clock
    input wire logic rst_n,              // Async reset, active low
    input wire logic in_valid,           // Write request
    output logic in_ready,               // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word written
    output logic out_valid,              // Word available
    input wire logic out_ready,          // Reader takes word
    output logic [WIDTH-1:0] out_data    // Oldest word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    // Wrapping pointers only serve power-of-two depths
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_depth_check
        $error("byte_fifo needs a width of 1 or more and a power-of-two depth of 2 or more");
    end

    assign in_ready = (count_q != DEPTH[AW:0]);
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_ptr_q];

    always_ff @(posedge clock)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end
endmodule

module api_frame_command_handler (
    input wire logic clock,                                  // 20 MHz system clock
    input wire logic rst_n,                                  // Async reset, active low
    input wire logic rx_valid,                               // Host byte available
    input wire logic [7:0] rx_data,                          // Host byte
    output logic rx_ready,                                   // Parser takes byte
    output logic tx_valid,                                   // Answer byte available
    output logic [7:0] tx_data,                              // Answer byte
    input wire logic tx_ready,                               // UART takes answer byte
    output logic tx_start,                                   // Pulse: start radio send
    output logic [7:0] tx_start_id,                          // Identifier of that send
    input wire logic result_valid,                           // Radio send finished
    input wire api_frame_pkg::radio_result_s result,         // Its identifier and code
    output logic result_ready,                               // Result taken
    input wire logic radio_rx_valid,                         // Radio payload byte
    input wire logic [7:0] radio_rx_byte,                    // Payload byte value
    output logic radio_rx_ready,                             // Payload taken
    input wire logic remote_valid,                           // Remote command finished
    input wire logic remote_heard,                           // Far end received it
    input wire api_frame_pkg::radio_result_s remote_result,  // Identifier and status
    output logic remote_ready,                               // Remote result taken
    output api_frame_pkg::param_set_s active_params,         // Parameters in effect
    output logic changes_pending,                            // Queued changes exist
    output logic frame_error                                 // Pulse: checksum failed
);
    import api_frame_pkg::*;

    typedef enum logic [2:0] {HUNT, LEN_HI, LEN_LO, BODY, CSUM, EXEC} parse_e;

    parse_e state_q;
    logic [15:0] len_q;
    logic [15:0] body_cnt_q;
    logic [7:0] sum_q;
    logic [7:0] type_q;
    logic [7:0] id_q;
    logic [15:0] name_q;
    logic [31:0] value_q;
    logic [2:0] val_cnt_q;
    logic bad_q;
    param_set_s pending_q;
    param_set_s active_q;
    param_set_s pend_d;
    logic [7:0] resp_q [0:RESP_MAX-1];
    logic [3:0] resp_len_q;
    logic [3:0] emit_idx_q;
    logic [7:0] out_sum_q;
    logic emit_busy_q;
    logic tx_start_q;
    logic [7:0] tx_start_id_q;
    logic frame_error_q;
    logic [7:0] ld_bytes [0:RESP_MAX-1];
    logic [3:0] ld_len;
    logic ld_valid;
    logic rx_take;
    logic exec_fire;
    logic is_param;
    logic is_query;
    logic known;
    logic apply_now;
    logic [7:0] read_val;
    logic [7:0] emit_byte;
    logic fifo_in_ready;
    logic emit_push;
    logic [7:0] next_sum;

    // Body sum including the byte now arriving
    function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
        add8 = a + b;
    endfunction

    assign rx_take = rx_valid && rx_ready;
    assign rx_ready = (state_q != EXEC);
    assign next_sum = add8(sum_q, rx_data);
    assign exec_fire = (state_q == EXEC) && !emit_busy_q;
    assign is_param = (type_q == TYPE_PARAM_NOW) || (type_q == TYPE_PARAM_QUEUED);
    assign is_query = (val_cnt_q == 3'd0);
    assign known = (name_q == NAME_RX_FORMAT) || (name_q == NAME_BAUD)
                   || (name_q == NAME_JOIN) || (name_q == NAME_APPLY);
    // apply on immediate type or apply command
    assign apply_now = exec_fire && !bad_q && is_param
                       && ((type_q == TYPE_PARAM_NOW) || (name_q == NAME_APPLY));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= HUNT;
            len_q <= '0;
            body_cnt_q <= '0;
            sum_q <= '0;
            bad_q <= 1'b0;
        end
        else if (state_q == EXEC)
        begin
            if (exec_fire)
                state_q <= HUNT;
        end
        else if (rx_take)
        begin
            unique case (state_q)
                HUNT:
                begin
                    if (rx_data == START_DELIM)
                        state_q <= LEN_HI;
                end
                LEN_HI:
                begin
                    len_q <= {rx_data, 8'h00};
                    state_q <= LEN_LO;
                end
                LEN_LO:
                begin
                    len_q <= {len_q[15:8], rx_data};
                    body_cnt_q <= '0;
                    sum_q <= '0;
                    state_q <= ({len_q[15:8], rx_data} == 16'h0000) ? HUNT : BODY;
                end
                BODY:
                begin
                    sum_q <= next_sum;
                    body_cnt_q <= body_cnt_q + 16'h0001;
                    if (body_cnt_q == len_q - 16'h0001)
                        state_q <= CSUM;
                end
                CSUM:
                begin
                    bad_q <= (next_sum != CSUM_GOOD);
                    state_q <= EXEC;
                end
                EXEC:
                    state_q <= EXEC;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            type_q <= '0;
            id_q <= '0;
            name_q <= '0;
            value_q <= '0;
            val_cnt_q <= '0;
        end
        else if (rx_take && state_q == LEN_LO)
        begin
            value_q <= '0;
            val_cnt_q <= '0;
        end
        else if (rx_take && state_q == BODY)
        begin
            if (body_cnt_q == 16'h0000)
                type_q <= rx_data;
            else if (body_cnt_q == 16'h0001)
                id_q <= rx_data;
            else if (body_cnt_q == 16'h0002)
                name_q <= {rx_data, name_q[7:0]};
            else if (body_cnt_q == 16'h0003)
                name_q <= {name_q[15:8], rx_data};
            else
            begin
                value_q <= {value_q[23:0], rx_data};
                if (val_cnt_q != 3'd7)
                    val_cnt_q <= val_cnt_q + 3'd1;
            end
        end
    end

    // new value lands in pending copy
    always_comb
    begin
        pend_d = pending_q;
        if (!is_query && val_cnt_q <= MAX_VALUE_BYTES)
        begin
            if (name_q == NAME_RX_FORMAT)
                pend_d.receive_format_select = value_q[7:0];
            else if (name_q == NAME_BAUD)
                pend_d.baud_select_param = value_q[7:0];
            else if (name_q == NAME_JOIN)
                pend_d.join_permit_param = value_q[7:0];
        end
    end

    // active set changes only on apply
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_q <= '{RX_FORMAT_RESET, BAUD_RESET, JOIN_RESET};
            active_q <= '{RX_FORMAT_RESET, BAUD_RESET, JOIN_RESET};
        end
        else if (exec_fire && !bad_q && is_param)
        begin
            pending_q <= pend_d;
            if (apply_now)
                active_q <= pend_d;
        end
    end

    always_comb
    begin
        read_val = ZERO_BYTE;
        if (name_q == NAME_RX_FORMAT)
            read_val = pending_q.receive_format_select;
        else if (name_q == NAME_BAUD)
            read_val = pending_q.baud_select_param;
        else if (name_q == NAME_JOIN)
            read_val = pending_q.join_permit_param;
    end

    // Answer assembly; parser execution outranks radio events
    always_comb
    begin
        for (int i = 0; i < RESP_MAX; i++)
            ld_bytes[i] = ZERO_BYTE;
        ld_len = 4'd0;
        ld_valid = 1'b0;
        result_ready = 1'b0;
        radio_rx_ready = 1'b0;
        remote_ready = 1'b0;
        if (exec_fire)
        begin
            if (bad_q)
            begin
                ld_valid = 1'b1;
                ld_len = 4'd2;
                ld_bytes[0] = TYPE_MODEM_STATUS;
                ld_bytes[1] = MODEM_BAD_FRAME;
            end
            else if (is_param && id_q != ZERO_BYTE)
            begin
                ld_valid = 1'b1;
                ld_len = (is_query && name_q != NAME_APPLY) ? 4'd6 : 4'd5;
                ld_bytes[0] = TYPE_PARAM_RESP;
                ld_bytes[1] = id_q;
                ld_bytes[2] = name_q[15:8];
                ld_bytes[3] = name_q[7:0];
                ld_bytes[4] = !known ? RESP_BAD_PARAM
                              : (val_cnt_q > MAX_VALUE_BYTES) ? RESP_ERROR : RESP_OK;
                ld_bytes[5] = read_val;
            end
        end
        else if (state_q != EXEC && !emit_busy_q)
        begin
            if (result_valid)
            begin
                result_ready = 1'b1;
                ld_valid = (result.frame_id != ZERO_BYTE);
                ld_len = 4'd7;
                ld_bytes[0] = TYPE_TX_STATUS;
                ld_bytes[1] = result.frame_id;
                ld_bytes[2] = ADDR16_UNKNOWN[15:8];
                ld_bytes[3] = ADDR16_UNKNOWN[7:0];
                ld_bytes[5] = result.code;
            end
            else if (radio_rx_valid)
            begin
                radio_rx_ready = 1'b1;
                ld_valid = 1'b1;
                ld_len = 4'd2;
                ld_bytes[0] = (active_q.receive_format_select == ZERO_BYTE)
                              ? TYPE_RX_PLAIN : TYPE_RX_EXPLICIT;
                ld_bytes[1] = radio_rx_byte;
            end
            else if (remote_valid)
            begin
                remote_ready = 1'b1;
                ld_valid = remote_heard;
                ld_len = 4'd3;
                ld_bytes[0] = TYPE_REMOTE_RESP;
                ld_bytes[1] = remote_result.frame_id;
                ld_bytes[2] = remote_result.code;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (ld_valid)
            for (int i = 0; i < RESP_MAX; i++)
                resp_q[i] <= ld_bytes[i];
    end

    always_comb
    begin
        if (emit_idx_q == 4'd0)
            emit_byte = START_DELIM;
        else if (emit_idx_q == 4'd1)
            emit_byte = ZERO_BYTE;
        else if (emit_idx_q == 4'd2)
            emit_byte = {4'h0, resp_len_q};
        else if (emit_idx_q == resp_len_q + 4'd3)
            emit_byte = CSUM_GOOD - out_sum_q;
        else
            emit_byte = resp_q[3'(emit_idx_q - 4'd3)];
    end

    assign emit_push = emit_busy_q && fifo_in_ready;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            emit_busy_q <= 1'b0;
            emit_idx_q <= '0;
            resp_len_q <= '0;
            out_sum_q <= '0;
        end
        else if (!emit_busy_q)
        begin
            if (ld_valid)
            begin
                emit_busy_q <= 1'b1;
                emit_idx_q <= '0;
                resp_len_q <= ld_len;
                out_sum_q <= '0;
            end
        end
        else if (emit_push)
        begin
            emit_idx_q <= emit_idx_q + 4'd1;
            if (emit_idx_q >= 4'd3 && emit_idx_q != resp_len_q + 4'd3)
                out_sum_q <= add8(out_sum_q, emit_byte);
            if (emit_idx_q == resp_len_q + 4'd3)
                emit_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_start_q <= 1'b0;
            tx_start_id_q <= '0;
            frame_error_q <= 1'b0;
        end
        else
        begin
            tx_start_q <= exec_fire && !bad_q && (type_q == TYPE_TX_REQ);
            if (exec_fire && !bad_q && (type_q == TYPE_TX_REQ))
                tx_start_id_q <= id_q;
            frame_error_q <= exec_fire && bad_q;
        end
    end

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .in_valid(emit_busy_q),
        .in_ready(fifo_in_ready),
        .in_data(emit_byte),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    assign tx_start = tx_start_q;
    assign tx_start_id = tx_start_id_q;
    assign frame_error = frame_error_q;
    assign active_params = active_q;
    assign changes_pending = (pending_q != active_q);

    sequence s_delim_seen;
        state_q == HUNT && rx_take && rx_data == START_DELIM;
    endsequence

    sequence s_csum_fail;
        state_q == CSUM && rx_take && next_sum != CSUM_GOOD;
    endsequence

    sequence s_bad_retire;
        exec_fire && bad_q;
    endsequence

    a_frame_sync: assert property (@(posedge clock) disable iff (!rst_n)
        s_delim_seen |=> state_q == LEN_HI)
        else $error("delimiter did not start length capture");
    a_hunt_drop: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == HUNT && rx_take && rx_data != START_DELIM) |=> state_q == HUNT)
        else $error("stray byte left hunt state");
    a_csum_verdict: assert property (@(posedge clock) disable iff (!rst_n)
        s_csum_fail |=> state_q == EXEC && bad_q)
        else $error("failed checksum not flagged");
    a_bad_frame_status: assert property (@(posedge clock) disable iff (!rst_n)
        s_bad_retire |=> resp_q[0] == TYPE_MODEM_STATUS
        && frame_error && $stable(active_q))
        else $error("bad checksum not reported or executed");
    a_zero_id_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (exec_fire && !bad_q && is_param && id_q == ZERO_BYTE) |-> !ld_valid)
        else $error("response sent for zero identifier");
    a_tx_status_code: assert property (@(posedge clock) disable iff (!rst_n)
        (result_ready && result_valid && result.frame_id != ZERO_BYTE) |=> emit_busy_q
        && resp_q[0] == TYPE_TX_STATUS && resp_q[5] == $past(result.code))
        else $error("transmit status missing or wrong code");
    a_rx_format_type: assert property (@(posedge clock) disable iff (!rst_n)
        (radio_rx_ready && radio_rx_valid) |=> resp_q[0] ==
        (($past(active_q.receive_format_select) == ZERO_BYTE) ? TYPE_RX_PLAIN
        : TYPE_RX_EXPLICIT))
        else $error("received frame type ignores format setting");
    a_remote_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        (remote_ready && remote_valid && !remote_heard) |=> !emit_busy_q)
        else $error("remote response emitted though not heard");
    a_apply_now: assert property (@(posedge clock) disable iff (!rst_n)
        (exec_fire && !bad_q && type_q == TYPE_PARAM_NOW) |=> active_q == pending_q)
        else $error("immediate command did not apply changes");
    a_queued_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (exec_fire && type_q == TYPE_PARAM_QUEUED && name_q != NAME_APPLY)
        |=> $stable(active_q))
        else $error("queued value took effect early");
endmodule

`default_nettype wire

// ---- hdl/api_frame_pkg.sv ----
// Purpose: Shared constants and carriers for the serial API frame handler
// Assumes: Byte streams arrive already deserialised by the UART
// Notes: Parameter name constants are two ASCII characters, high byte first
package api_frame_pkg;
    localparam logic [7:0] START_DELIM = 8'h7E;
    localparam logic [7:0] TYPE_PARAM_NOW = 8'h08;
    localparam logic [7:0] TYPE_PARAM_QUEUED = 8'h09;
    localparam logic [7:0] TYPE_TX_REQ = 8'h10;
    localparam logic [7:0] TYPE_PARAM_RESP = 8'h88;
    localparam logic [7:0] TYPE_MODEM_STATUS = 8'h8A;
    localparam logic [7:0] TYPE_TX_STATUS = 8'h8B;
    localparam logic [7:0] TYPE_RX_PLAIN = 8'h90;
    localparam logic [7:0] TYPE_RX_EXPLICIT = 8'h91;
    localparam logic [7:0] TYPE_REMOTE_RESP = 8'h97;
    localparam logic [7:0] CSUM_GOOD = 8'hFF;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [15:0] ADDR16_UNKNOWN = 16'hFFFE;
    localparam logic [15:0] NAME_RX_FORMAT = 16'h4150;
    localparam logic [15:0] NAME_APPLY = 16'h4143;
    localparam logic [15:0] NAME_JOIN = 16'h4E4A;
    localparam logic [15:0] NAME_BAUD = 16'h4244;
    localparam logic [7:0] RX_FORMAT_RESET = 8'h00;
    localparam logic [7:0] BAUD_RESET = 8'h03;
    localparam logic [7:0] JOIN_RESET = 8'hFF;
    localparam logic [7:0] RESP_OK = 8'h00;
    localparam logic [7:0] RESP_ERROR = 8'h01;
    localparam logic [7:0] RESP_BAD_PARAM = 8'h03;
    localparam logic [7:0] MODEM_BAD_FRAME = 8'h01;
    localparam logic [2:0] MAX_VALUE_BYTES = 3'd4;
    localparam int RESP_MAX = 8;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [7:0] receive_format_select;
        logic [7:0] baud_select_param;
        logic [7:0] join_permit_param;
    } param_set_s;

    typedef struct packed {
        logic [7:0] frame_id;
        logic [7:0] code;
    } radio_result_s;
endpackage

// ---- tb/host_model.sv ----
// Purpose: Host side of the serial API byte streams
// Assumes: One byte moves per accepted handshake
// Notes: Collects every answer byte, whatever its frame type
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock,         // System clock
    input wire logic rx_ready,      // Design takes byte
    output logic rx_valid,          // Byte offered
    output logic [7:0] rx_data,     // Byte value
    input wire logic tx_valid,      // Answer byte available
    input wire logic [7:0] tx_data, // Answer byte
    output logic tx_ready,          // Take answer byte
    input wire logic stall          // Hold off answers
);
    logic [7:0] got[$];
    assign tx_ready = !stall;
    always @(posedge clock)
    begin
        if (tx_valid === 1'b1 && tx_ready)
            got.push_back(tx_data);
    end
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i])
        begin
            rx_valid = 1'b1;
            rx_data = b[i];
            while (rx_ready !== 1'b1) @(posedge clock) #1;
            @(posedge clock) #1;
        end
        // Released line shows the inverse, never a stale byte
        rx_valid = 1'b0;
        rx_data = ~rx_data;
        @(posedge clock) #1;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the API frame handler
// Assumes: Host model drives frames; bench drives radio events
// Notes: Stall during a queued command fills the answer FIFO
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import api_frame_pkg::*;
    typedef logic [7:0] byte_q_t[$];
    logic clock = 1'b0, rst_n = 1'b0, stall = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, tx_start, frame_error;
    logic [7:0] rx_data, tx_data, tx_start_id, radio_rx_byte = 8'h3C;
    logic result_valid = 1'b0, radio_rx_valid = 1'b0, remote_valid = 1'b0;
    logic result_ready, radio_rx_ready, remote_ready, remote_heard = 1'b0;
    logic changes_pending;
    radio_result_s result = 16'h0000, remote_result = 16'h0900;
    param_set_s active_params;
    int failures = 0, check_count = 0, err_seen = 0, start_seen = 0;
    logic [7:0] start_id_q = 8'h00;
    always #25 clock = ~clock;
    api_frame_command_handler dut (.clock(clock), .rst_n(rst_n), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_start(tx_start), .tx_start_id(tx_start_id),
        .result_valid(result_valid), .result(result), .result_ready(result_ready),
        .radio_rx_valid(radio_rx_valid), .radio_rx_byte(radio_rx_byte),
        .radio_rx_ready(radio_rx_ready), .remote_valid(remote_valid),
        .remote_heard(remote_heard), .remote_result(remote_result),
        .remote_ready(remote_ready), .active_params(active_params),
        .changes_pending(changes_pending), .frame_error(frame_error));
    host_model host (.clock(clock), .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .stall(stall));
    always @(posedge clock)
    begin
        if (frame_error === 1'b1) err_seen++;
        if (tx_start === 1'b1) begin start_seen++; start_id_q <= tx_start_id; end
    end
    task automatic report_and_stop();
        $display("Checks %0d, failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Delimiter, big-endian length, body, checksum
    function automatic byte_q_t frame(input byte_q_t p);
        logic [7:0] s = 8'h00;
        foreach (p[i]) s += p[i];
        return {START_DELIM, 8'h00, 8'(p.size()), p, CSUM_GOOD - s};
    endfunction
    task automatic expect_frame(input byte_q_t p);
        byte_q_t e = frame(p);
        int n = 0;
        while (host.got.size() < e.size() && n < 300) begin @(posedge clock) #1; n++; end
        repeat (10) @(posedge clock) #1;
        check_byte("answer length", 8'(e.size()), 8'(host.got.size()));
        foreach (e[i]) if (i < host.got.size()) check_byte("answer byte", e[i], host.got[i]);
        host.got.delete();
    endtask
    task automatic expect_none();
        repeat (60) @(posedge clock) #1;
        check_byte("silent answer", 8'h00, 8'(host.got.size()));
        host.got.delete();
    endtask
    task automatic offer(input int k);
        int n = 0;
        {result_valid, radio_rx_valid, remote_valid} = 3'b100 >> k;
        // Ready is judged at the rising edge itself, so the event is taken once
        do
        begin
            @(posedge clock);
            n++;
        end
        while ((k == 0 ? result_ready : k == 1 ? radio_rx_ready : remote_ready) !== 1'b1
               && n < 100);
        #1;
        {result_valid, radio_rx_valid, remote_valid} = 3'b000;
    endtask
    task automatic t_set_now();
        host.send(frame({8'h08, 8'h01, 8'h4E, 8'h4A, 8'h22}));
        expect_frame({8'h88, 8'h01, 8'h4E, 8'h4A, 8'h00});
        check_byte("join", 8'h22, active_params.join_permit_param);
        host.send(frame({8'h08, 8'h00, 8'h4E, 8'h4A, 8'h00, 8'h33}));
        expect_none();
        check_byte("join two byte", 8'h33, active_params.join_permit_param);
        host.send(frame({8'h08, 8'h02, 8'h4E, 8'h4A, 8'h00, 8'h00, 8'h00, 8'h44}));
        expect_frame({8'h88, 8'h02, 8'h4E, 8'h4A, 8'h00});
        check_byte("join four byte", 8'h44, active_params.join_permit_param);
    endtask
    task automatic t_queued();
        stall = 1'b1;
        host.send(frame({8'h09, 8'h03, 8'h42, 8'h44, 8'h07}));
        repeat (40) @(posedge clock) #1;
        check_byte("stalled valid", 8'h01, {7'h00, tx_valid});
        stall = 1'b0;
        expect_frame({8'h88, 8'h03, 8'h42, 8'h44, 8'h00});
        check_byte("baud held", 8'h03, active_params.baud_select_param);
        check_byte("pending", 8'h01, {7'h00, changes_pending});
        host.send(frame({8'h09, 8'h04, 8'h42, 8'h44}));
        expect_frame({8'h88, 8'h04, 8'h42, 8'h44, 8'h00, 8'h07});
        host.send(frame({8'h08, 8'h00, 8'h41, 8'h43}));
        expect_none();
        check_byte("baud applied", 8'h07, active_params.baud_select_param);
        check_byte("pending clear", 8'h00, {7'h00, changes_pending});
    endtask
    task automatic t_bad_frames();
        byte_q_t b = frame({8'h08, 8'h05, 8'h4E, 8'h4A, 8'h11});
        b[$] = b[$] ^ 8'h01;
        host.send({8'h11, 8'h22, b});
        expect_frame({8'h8A, 8'h01});
        check_byte("error pulses", 8'h01, 8'(err_seen));
        check_byte("join kept", 8'h44, active_params.join_permit_param);
        host.send({8'h55, 8'h00, frame({8'h08, 8'h06, 8'h4E, 8'h4A})});
        expect_frame({8'h88, 8'h06, 8'h4E, 8'h4A, 8'h00, 8'h44});
        host.send(frame({8'h08, 8'h08, 8'h4E, 8'h44, 8'h01}));
        expect_frame({8'h88, 8'h08, 8'h4E, 8'h44, 8'h03});
        host.send(frame({8'h08, 8'h09, 8'h4E, 8'h4A, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05}));
        expect_frame({8'h88, 8'h09, 8'h4E, 8'h4A, 8'h01});
        check_byte("join over long", 8'h44, active_params.join_permit_param);
    endtask
    task automatic t_radio();
        host.send(frame({8'h10, 8'h05, 8'hAB}));
        expect_none();
        check_byte("start id", 8'h05, start_id_q);
        check_byte("start count", 8'h01, 8'(start_seen));
        result = 16'h0521;
        offer(0);
        expect_frame({8'h8B, 8'h05, 8'hFF, 8'hFE, 8'h00, 8'h21, 8'h00});
        result = 16'h0021;
        offer(0);
        expect_none();
        offer(1);
        expect_frame({8'h90, 8'h3C});
        host.send(frame({8'h08, 8'h07, 8'h41, 8'h50, 8'h01}));
        expect_frame({8'h88, 8'h07, 8'h41, 8'h50, 8'h00});
        check_byte("format", 8'h01, active_params.receive_format_select);
        offer(1);
        expect_frame({8'h91, 8'h3C});
        offer(2);
        expect_none();
        remote_heard = 1'b1;
        offer(2);
        expect_frame({8'h97, 8'h09, 8'h00});
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        report_and_stop();
    end
    initial
    begin
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        check_byte("baud reset", BAUD_RESET, active_params.baud_select_param);
        t_set_now();
        t_queued();
        t_bad_frames();
        t_radio();
        report_and_stop();
    end
endmodule
`default_nettype wire
